// ===== pkg/reset_startup_defines.svh
// Offsets, field positions, reset values and timing counts
// Notes on behaviour
// - 11-bit delay counter on slow oscillator, 2048 ticks
// - Core held in reset while delay counts
// - Delay runs only when disable bit is zero
// - Then count 1024 oscillator pin edges
// - Pin count only in crystal or resonator modes
// - Pin count only after power-on or wake
// - PLL mode adds fixed 2 ms lock wait
// - Start after power-on pulse; delay, then count
// - Resistor-capacitor mode without delay: no time-out
// - Timers ignore clear pin; release when pin rises
// - Nominal delay about 66 ms in every mode
`ifndef RESET_STARTUP_DEFINES_SVH
`define RESET_STARTUP_DEFINES_SVH

// Register byte offsets
`define CFG_OFS      12'h000
`define STATUS_OFS   12'h004
`define WAKE_OFS     12'h008
`define COUNT_OFS    12'h00c

// Configuration register fields and reset value
`define CFG_MODE_LSB      0
`define CFG_MODE_MSB      3
`define CFG_DELAY_DIS_BIT 4
`define CFG_RST           5'h02

// Wake register: bit that starts the restart count
`define WAKE_GO_BIT  0

// Status register fields
`define ST_RESET_BIT 3
`define ST_HOLD_BIT  4
`define ST_PIN_BIT   5

// Timer terminal counts
`define DELAY_LAST   11'h7ff
`define SETTLE_LAST  10'h3ff

// Lock wait and clock period in ns
`define PLL_LOCK_NS  2000000
`define CLK_NS       4

`endif

// ===== pkg/reset_startup_pkg.sv
// Types shared by the reset start-up sequencer
package reset_startup_pkg;

  // Oscillator configuration modes
  typedef enum logic [3:0] {
    low_power_crystal_mode          = 4'h0,
    crystal_mode                    = 4'h1,
    high_speed_crystal_mode         = 4'h2,
    high_speed_crystal_pll_mode     = 4'h3,
    resistor_capacitor_osc_mode     = 4'h4,
    resistor_capacitor_osc_io_mode  = 4'h5,
    external_clock_mode             = 4'h6,
    external_clock_io_mode          = 4'h7,
    internal_osc_clkout_mode        = 4'h8,
    internal_osc_io_mode            = 4'h9
  } osc_mode_t;

  // Sequencer states
  typedef enum logic [2:0] {
    SEQ_POR    = 3'h0,
    SEQ_DELAY  = 3'h1,
    SEQ_SETTLE = 3'h2,
    SEQ_PLL    = 3'h3,
    SEQ_RUN    = 3'h4
  } seq_state_t;

  // APB request from the master
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  // APB answer to the master
  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } apb_rsp_t;

endpackage

// ===== hw/reset_startup_timers.sv
// Power-up reset sequencer with start-up timers and APB registers
`timescale 1ns/1ns
`include "reset_startup_defines.svh"

module reset_startup_timers #(
  // Lock wait in cycles; shorten for simulation
  parameter int PLL_CYCLES =
    (`PLL_LOCK_NS + `CLK_NS - 1) / `CLK_NS
) (
  // Clock and reset
  input  wire logic                       sys_clk_in,
  input  wire logic                       rstn_in,
  // Reset sources
  input  wire logic                       por_pulse_in,
  input  wire logic                       master_clear_pin_n_in,
  // Clock sources being timed
  input  wire logic                       low_freq_internal_osc_in,
  input  wire logic                       oscillator_input_pin_in,
  // Register bus
  input  wire reset_startup_pkg::apb_req_t apb_req_in,
  output      reset_startup_pkg::apb_rsp_t apb_rsp_out,
  // Results
  output      logic                       core_reset_out,
  output      logic                       clock_hold_out
);
  import reset_startup_pkg::*;

  // Mode needs the pin start-up count: only a crystal or
  // resonator needs time to build up its swing
  function automatic logic needs_settle(input osc_mode_t m);
    needs_settle = (m == low_power_crystal_mode) ||
                (m == crystal_mode) ||
                (m == high_speed_crystal_mode) ||
                (m == high_speed_crystal_pll_mode);
  endfunction

  // Mode needs the PLL lock wait
  function automatic logic needs_pll(input osc_mode_t m);
    needs_pll = (m == high_speed_crystal_pll_mode);
  endfunction

  // One step of the shared timer; the count never wraps
  // because every state leaves before the top value
  function automatic logic [19:0] count_up(input logic [19:0] c);
    count_up = c + 20'h00001;
  endfunction

  // Sequencer state
  seq_state_t  state_r;
  seq_state_t  state_nxt;
  // Shared timer count, wide enough for lock wait
  logic [19:0] cnt_r;
  logic [19:0] cnt_nxt;
  // Set once the power-on sequence has finished
  logic        por_done_r;
  logic        por_done_nxt;
  // Previous levels for edge detection
  logic        lf_prev_r;
  logic        lf_prev_nxt;
  logic        osc_prev_r;
  logic        osc_prev_nxt;
  // Registered outputs
  logic        core_reset_r;
  logic        core_reset_nxt;
  logic        clock_hold_r;
  logic        clock_hold_nxt;

  // Configuration register
  logic [4:0]  cfg_r;
  logic [4:0]  cfg_nxt;
  // Bus answer register
  apb_rsp_t    rsp_r;
  apb_rsp_t    rsp_nxt;

  // Decoded configuration
  osc_mode_t   mode;      // Oscillator mode field
  logic        delay_dis; // High skips the power-up delay
  // Rising edges of the timed clocks
  logic        lf_edge;
  logic        osc_edge;
  // Bus decode helpers
  logic        acc_done;
  logic        wr_done;
  logic        wake_req;
  logic [11:0] ofs;
  logic        hit;

  // Codes above the last mode decode as no crystal, so a bad
  // write can only shorten the sequence, never hang it
  assign mode      = osc_mode_t'(cfg_r[`CFG_MODE_MSB:`CFG_MODE_LSB]);
  assign delay_dis = cfg_r[`CFG_DELAY_DIS_BIT];
  // Inputs are synchronous, so a plain edge detect suffices;
  // the history resets low to match the idle level of both
  assign lf_edge  = low_freq_internal_osc_in & ~lf_prev_r;
  assign osc_edge = oscillator_input_pin_in & ~osc_prev_r;

  // APB decode: a transfer completes when pready is seen high;
  // writes act only then, so a master that aborts a transfer
  // before its ready edge leaves the registers untouched
  assign acc_done = apb_req_in.psel & apb_req_in.penable &
                    rsp_r.pready;
  assign wr_done  = acc_done & apb_req_in.pwrite;
  assign ofs      = apb_req_in.paddr[11:0];
  assign hit      = (apb_req_in.paddr[31:12] == 20'h00000) &&
                    ((ofs == `CFG_OFS) || (ofs == `STATUS_OFS) ||
                     (ofs == `WAKE_OFS) || (ofs == `COUNT_OFS));
  // Wake command, only counted if the write really lands
  assign wake_req = wr_done && hit && (ofs == `WAKE_OFS) &&
                    apb_req_in.pwdata[`WAKE_GO_BIT];

  // Sequencer next state: one shared counter serves all three
  // timers, as they never run at the same time
  always_comb begin
    state_nxt    = state_r;
    cnt_nxt      = cnt_r;
    por_done_nxt = por_done_r;
    if (por_pulse_in) begin
      // Power-on pulse restarts everything, whatever the pin
      state_nxt    = SEQ_POR;
      cnt_nxt      = 20'h00000;
      por_done_nxt = 1'b0;
    end else begin
      unique case (state_r)
        SEQ_POR: begin
          // Pulse has ended: choose the first timer
          cnt_nxt = 20'h00000;
          if (!delay_dis) begin
            // Delay enabled while its bit is clear
            state_nxt = SEQ_DELAY;
          end else if (needs_settle(mode)) begin
            // Delay skipped: straight to the pin count
            state_nxt = SEQ_SETTLE;
          end else begin
            // No time-out at all, as for a resistor-capacitor clock
            state_nxt = SEQ_RUN;
          end
        end
        SEQ_DELAY: begin
          // Count slow oscillator periods, about 66 ms; the
          // count is held, not cleared, between slow edges
          if (lf_edge) begin
            if (cnt_r[10:0] == `DELAY_LAST) begin
              // Last of 2048 periods seen
              cnt_nxt = 20'h00000;
              if (needs_settle(mode)) begin
                // Crystal modes go on to the pin count
                state_nxt = SEQ_SETTLE;
              end else begin
                // Clock needs no build-up: sequence done
                state_nxt = SEQ_RUN;
              end
            end else begin
              cnt_nxt = count_up(cnt_r);
            end
          end
        end
        SEQ_SETTLE: begin
          // Count pin edges until the crystal settles; after power-on a
          // dead crystal keeps the core in reset for good
          if (osc_edge) begin
            if (cnt_r[9:0] == `SETTLE_LAST) begin
              // Last of 1024 pin cycles seen
              cnt_nxt = 20'h00000;
              if (needs_pll(mode)) begin
                // Multiplier must lock before release
                state_nxt = SEQ_PLL;
              end else begin
                // No multiplier: sequence done
                state_nxt = SEQ_RUN;
              end
            end else begin
              cnt_nxt = count_up(cnt_r);
            end
          end
        end
        SEQ_PLL: begin
          // Fixed lock wait on the system clock, since the
          // multiplied clock itself cannot be trusted yet
          if (cnt_r == 20'(PLL_CYCLES - 1)) begin
            cnt_nxt   = 20'h00000;
            state_nxt = SEQ_RUN;
          end else begin
            cnt_nxt = count_up(cnt_r);
          end
        end
        SEQ_RUN: begin
          // Power-on sequence finished; stays set until a pulse
          por_done_nxt = 1'b1;
          // Wake from a mode that stopped the oscillator; the
          // core keeps running, only the clock is held
          if (wake_req && needs_settle(mode)) begin
            state_nxt = SEQ_SETTLE;
            cnt_nxt   = 20'h00000;
          end
        end
        default: begin
          // Illegal code: restart the power-on path
          state_nxt    = SEQ_POR;
          cnt_nxt      = 20'h00000;
          por_done_nxt = 1'b0;
        end
      endcase
    end
    // Reset held while any power-on timer runs or the
    // pin is low; the pin never stops the timers
    core_reset_nxt = ~(por_done_nxt &&
                       master_clear_pin_n_in);
    // Hold also covers a wake restart, unlike the core reset
    clock_hold_nxt = (state_nxt != SEQ_RUN);
  end

  // Sequencer registers
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_r      <= SEQ_POR;
      cnt_r        <= 20'h00000;
      por_done_r   <= 1'b0;
      core_reset_r <= 1'b1;
      clock_hold_r <= 1'b1;
    end else begin
      state_r      <= state_nxt;
      cnt_r        <= cnt_nxt;
      por_done_r   <= por_done_nxt;
      core_reset_r <= core_reset_nxt;
      clock_hold_r <= clock_hold_nxt;
    end
  end

  // Edge history next values: last sampled level of each clock
  always_comb begin
    lf_prev_nxt  = low_freq_internal_osc_in;
    osc_prev_nxt = oscillator_input_pin_in;
  end

  // Edge history registers
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      // Low matches the idle level, so no false edge after reset
      lf_prev_r  <= 1'b0;
      osc_prev_r <= 1'b0;
    end else begin
      lf_prev_r  <= lf_prev_nxt;
      osc_prev_r <= osc_prev_nxt;
    end
  end

  // Register bus next values
  always_comb begin
    cfg_nxt         = cfg_r;
    rsp_nxt         = rsp_r;
    // One wait state: pready is high in the second access cycle
    rsp_nxt.pready  = apb_req_in.psel & apb_req_in.penable &
                      ~rsp_r.pready;
    rsp_nxt.pslverr = 1'b0;
    rsp_nxt.prdata  = 32'h00000000;
    if (apb_req_in.psel && apb_req_in.penable &&
        !rsp_r.pready) begin
      // Unmapped address answers with an error
      rsp_nxt.pslverr = ~hit;
      if (!apb_req_in.pwrite && hit) begin
        unique case (ofs)
          `CFG_OFS: begin
            // Configuration reads back as written
            rsp_nxt.prdata = {27'h0, cfg_r};
          end
          `STATUS_OFS: begin
            // Live view of the sequencer and the pin
            rsp_nxt.prdata = {26'h0,
                              master_clear_pin_n_in,
                              clock_hold_r,
                              core_reset_r,
                              state_r};
          end
          `COUNT_OFS: begin
            // Count of whichever timer is running
            rsp_nxt.prdata = {12'h000, cnt_r};
          end
          default: begin
            // Wake register reads as zero
            rsp_nxt.prdata = 32'h00000000;
          end
        endcase
      end
    end
    // Configuration changes only on the completing edge
    if (wr_done && hit && (ofs == `CFG_OFS)) begin
      cfg_nxt = apb_req_in.pwdata[4:0];
    end
  end

  // Register bus registers
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cfg_r <= `CFG_RST;
      rsp_r <= '0;
    end else begin
      cfg_r <= cfg_nxt;
      rsp_r <= rsp_nxt;
    end
  end

  // Outputs straight from flip-flops, so nothing downstream
  // sees a glitch from the decode logic above
  assign apb_rsp_out    = rsp_r;
  assign core_reset_out = core_reset_r;
  assign clock_hold_out = clock_hold_r;

endmodule

// ===== test/reset_startup_timers_monitor.sv
// Port checker for the reset start-up sequencer
`timescale 1ns/1ns
module reset_startup_timers_monitor (
  // Clock and reset
  input wire logic                        sys_clk_in,
  input wire logic                        rstn_in,
  // Inputs
  input wire logic                        por_pulse_in,
  input wire logic                        master_clear_pin_n_in,
  input wire reset_startup_pkg::apb_req_t apb_req_in,
  // Outputs
  input wire reset_startup_pkg::apb_rsp_t apb_rsp_out,
  input wire logic                        core_reset_out,
  input wire logic                        clock_hold_out
);
  import reset_startup_pkg::*;
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rstn_in);
  wire rdy = apb_rsp_out.pready;  // Answer strobe
  wire err = apb_rsp_out.pslverr; // Refusal flag
  wire cr  = core_reset_out;      // Core reset
  // Address is one of the four mapped words
  wire hit = apb_req_in.paddr inside {32'h0, 32'h4, 32'h8, 32'hc};
  // First cycle of an access phase
  sequence s_access;
    apb_req_in.psel && $rose(apb_req_in.penable);
  endsequence
  a_ready_after_access: assert property (s_access |=> rdy)
    else $error("ready late");
  a_ready_one_cycle: assert property (rdy |=> !rdy)
    else $error("ready held");
  a_refuse_unmapped: assert property (rdy |-> err == !hit)
    else $error("wrong refusal");
  a_refused_reads_zero: assert property (rdy && err |-> !apb_rsp_out.prdata)
    else $error("refused data");
  a_por_holds_reset: assert property (por_pulse_in |=> cr)
    else $error("reset free in pulse");
  a_timer_holds_reset: assert property (clock_hold_out && cr |=> cr)
    else $error("reset free while timing");
  // Pin is synchronous, so release follows a high sample
  a_release_needs_pin: assert property (
    $fell(cr) |-> $past(master_clear_pin_n_in))
    else $error("release with pin low");
  // A low clear pin is itself a reset request, so it is excluded
  a_release_stays_low: assert property (
    !cr && !por_pulse_in && master_clear_pin_n_in |=> !cr)
    else $error("reset came back");
endmodule
bind reset_startup_timers reset_startup_timers_monitor
  reset_startup_timers_monitor_inst (.sys_clk_in(sys_clk_in),
  .rstn_in(rstn_in), .por_pulse_in(por_pulse_in),
  .master_clear_pin_n_in(master_clear_pin_n_in), .apb_req_in(apb_req_in),
  .apb_rsp_out(apb_rsp_out), .core_reset_out(core_reset_out),
  .clock_hold_out(clock_hold_out));

// ===== test/reset_startup_timers_test.sv
// Self-checking bench for the reset start-up sequencer
`timescale 1ns/1ns
module reset_startup_timers_test;
  import reset_startup_pkg::*;
  localparam int PLL = 20; // Short lock wait keeps runs brief
  localparam int OP  = 4;  // Oscillator period in clocks
  logic        clk = 0;    // System clock
  logic        rstn = 0;   // Reset, low at start
  logic        por = 1;    // Power-on pulse
  logic        pin_n = 1;  // Clear pin
  logic        slow = 0;   // Slow oscillator
  logic        xosc = 0;   // Pin oscillator
  apb_req_t    req = '0;   // Bus request
  apb_rsp_t    rsp;        // Bus answer
  logic        crst;       // Core reset
  logic        hold;       // Timer running
  logic [31:0] rd;         // Last read data
  logic        er;         // Last refusal
  int          mismatches = 0, checks = 0, cyc = 0;
  reset_startup_timers #(.PLL_CYCLES(PLL)) reset_startup_timers_inst (
    .sys_clk_in(clk), .rstn_in(rstn), .por_pulse_in(por),
    .master_clear_pin_n_in(pin_n), .low_freq_internal_osc_in(slow),
    .oscillator_input_pin_in(xosc), .apb_req_in(req), .apb_rsp_out(rsp),
    .core_reset_out(crst), .clock_hold_out(hold));
  always #2 clk = ~clk;
  // Free-running oscillators, out of phase, and the hang limit
  always @(posedge clk) begin
    cyc <= cyc + 1;
    slow <= cyc % OP < OP / 2;
    xosc <= (cyc + 1) % OP < OP / 2;
    if (cyc == 90000) begin
      mismatches++;
      end_of_test();
    end
  end
  task automatic chk(input logic [31:0] got, exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic chk_win(input int n, lo, hi);
    checks++;
    if (n < lo || n > hi) begin
      mismatches++;
      $display("Error at %0t: %0d cycles not %0d..%0d", $time, n, lo, hi);
    end
  endtask
  // Bus transfer; wait for ready, no fixed latency assumed
  task automatic xfer(input logic wr, input logic [31:0] a, d);
    @(posedge clk);
    req <= '{1'b1, 1'b0, wr, a, d};
    @(posedge clk);
    req.penable <= 1'b1;
    // Only the run's cycle limit ends a wait that never answers
    do @(posedge clk); while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    er = rsp.pslverr;
    req <= '0;
  endtask
  // Cycles from pulse end to release
  function automatic int span(osc_mode_t m, logic dis);
    span = dis ? 0 : 2048 * OP;
    if (m <= high_speed_crystal_pll_mode) span += 1024 * OP;
    if (m == high_speed_crystal_pll_mode) span += PLL;
  endfunction
  // Pulse, optionally hold the pin low past all timers, time release
  task automatic run(osc_mode_t m, logic dis, logic late);
    int n, e;
    e = span(m, dis);
    xfer(1'b1, 32'h0, {27'h0, dis, m});
    @(posedge clk);
    por <= 1'b1;
    pin_n <= !late;
    repeat (3) @(posedge clk);
    por <= 1'b0;
    if (late) begin
      repeat (e + 40) @(posedge clk);
      chk({31'h0, crst}, 32'h1);
      chk({31'h0, hold}, 32'h0);
      pin_n <= 1'b1;
      e = 0;
    end
    n = 0;
    do @(posedge clk); while (crst !== 1'b0 && ++n < e + 40);
    chk_win(n, e - 8, late ? 3 : e + 16);
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    int n;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    xfer(1'b0, 32'h0, 32'h0);
    chk(rd, 32'h2);
    xfer(1'b0, 32'h10, 32'h0);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
    run(high_speed_crystal_mode, 1'b0, 1'b0);
    run(high_speed_crystal_pll_mode, 1'b0, 1'b0);
    run(external_clock_mode, 1'b0, 1'b0);
    for (int m = 0; m < 10; m++) begin
      run(osc_mode_t'(m), 1'b1, 1'b0);
    end
    // Restart request in a non-crystal mode is ignored
    xfer(1'b1, 32'h8, 32'h1);
    repeat (3) @(posedge clk);
    chk({31'h0, hold}, 32'h0);
    // Crystal restart reruns only the pin count, core stays out
    run(low_power_crystal_mode, 1'b1, 1'b1);
    xfer(1'b1, 32'h8, 32'h1);
    repeat (3) @(posedge clk);
    chk({31'h0, hold}, 32'h1);
    n = 0;
    do @(posedge clk); while (hold !== 1'b0 && ++n < 5000);
    chk_win(n, 1024 * OP - 12, 1024 * OP + 16);
    chk({31'h0, crst}, 32'h0);
    // Status: pin high, no hold, core out of reset, run state
    xfer(1'b0, 32'h4, 32'h0);
    chk(rd, 32'h24);
    xfer(1'b0, 32'hc, 32'h0);
    chk(rd, 32'h0);
    end_of_test();
  end
endmodule
